// *** include/mmdec_pkg.sv ***
/*
 * Package for the memory map decoder: program space widths, vectors,
 * data space region bounds and variant encoding.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mmdec_pkg;

	// ==========================================================
	// Program space
	localparam int PC_W = 13;
	localparam int PWORD_W = 14;
	localparam int PADDR_SMALL_W = 10;
	localparam int PADDR_LARGE_W = 11;
	localparam logic [12:0] RESET_VECTOR = 13'h0000;
	localparam logic [12:0] INT_VECTOR = 13'h0004;

	// ==========================================================
	// Data space
	localparam int DADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int DIRECT_W = 7;
	localparam int RAM_IDX_W = 7;
	localparam int RAM_DEPTH = 128;
	localparam logic [6:0] SFR_COUNT = 7'h20;
	localparam logic [6:0] SMALL_RAM_LO = 7'h40;
	localparam logic [6:0] LARGE_RAM_LO = 7'h20;
	localparam logic [6:0] BANK0_RAM_HI = 7'h7f;
	localparam logic [7:0] BANK1_RAM_LO = 8'ha0;
	localparam logic [7:0] BANK1_RAM_HI = 8'hef;
	localparam logic [7:0] ALIAS_LO = 8'hf0;
	localparam logic [7:0] BANK1_RAM_BASE = 8'h40;
	localparam logic [7:0] DATA_RESET = 8'h00;

	// ==========================================================
	// Variant selection
	typedef enum logic [0:0] {
		MMDEC_SMALL = 1'b0,
		MMDEC_LARGE = 1'b1
	} mmdec_variant_t;

endpackage

// *** verilog/mmdec_ram.sv ***
/*
 * Flip-flop storage for the general purpose RAM, indexed by physical slot.
 * Assumes a single write port and a combinational read port.
 */
`timescale 1ns/1ps
`default_nettype none
module mmdec_ram #(
	parameter int DEPTH = mmdec_pkg::RAM_DEPTH,
	parameter int IDX_W = mmdec_pkg::RAM_IDX_W,
	parameter int WIDTH = mmdec_pkg::DATA_W
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic we_i,
	input wire logic [IDX_W-1:0] widx_i,
	input wire logic [WIDTH-1:0] wdata_i,
	input wire logic [IDX_W-1:0] ridx_i,
	output logic [WIDTH-1:0] rdata_o
);
	import mmdec_pkg::*;

	logic [WIDTH-1:0] mem_reg [DEPTH];

	// ==========================================================
	// Storage cells
	// One generate loop per entry keeps the reset value explicit per cell.
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_cell
			always_ff @(posedge clk_i) begin
				if (!nrst_i) begin
					mem_reg[g] <= WIDTH'(DATA_RESET);
				end else if (we_i && (widx_i == IDX_W'(g))) begin
					mem_reg[g] <= wdata_i;
				end
			end
		end
	endgenerate

	// Read is combinational; the caller registers the result.
	assign rdata_o = mem_reg[ridx_i];
endmodule
`default_nettype wire

// *** verilog/mmdec_top.sv ***
/*
 * Memory map decoder: program fetch address wrap, reset and interrupt
 * vectors, program counter, and banked data space decode with RAM.
 * Assumes the core drives fetch and data requests synchronous to clk_i,
 * and that special function registers live outside, answering on
 * sfr_rdata_i whenever sfr_sel_o is high.
 */
// Notes on behaviour
// - The program counter is 13 bits wide over an 8K space of 14-bit words.
// - The small variant implements program words 0000h to 03FFh only.
// - The large variant implements program words 0000h to 07FFh.
// - Fetch addresses above the implemented space wrap by dropping upper bits.
// - Reset starts at 0000h and an interrupt loads the vector 0004h.
// - Data space has two banks whose first 32 locations are special function registers.
// - The small variant implements bank 0 locations 40h to 7Fh as RAM.
// - The large variant implements 20h to 7Fh in bank 0 and A0h to EFh in bank 1.
// - Bank 1 locations F0h to FFh reach the same RAM as bank 0 locations 70h to 7Fh.
// - Reads of locations that are neither special registers nor RAM return zero.
// - The bank select bit picks bank 0 when low and bank 1 when high.
// - Every RAM location is reachable directly and through the file select pointer.
`timescale 1ns/1ps
`default_nettype none
module mmdec_top #(
	parameter mmdec_pkg::mmdec_variant_t VARIANT = mmdec_pkg::MMDEC_SMALL
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic pc_load_i,
	input wire logic [mmdec_pkg::PC_W-1:0] pc_load_val_i,
	input wire logic pc_inc_i,
	input wire logic irq_take_i,
	output logic [mmdec_pkg::PC_W-1:0] pc_o,
	output logic [mmdec_pkg::PC_W-1:0] fetch_addr_o,
	input wire logic [mmdec_pkg::PWORD_W-1:0] prog_word_i,
	output logic [mmdec_pkg::PWORD_W-1:0] instr_o,
	input wire logic bank_select_bit_i,
	input wire logic upper_bank_bit_i,
	input wire logic indirect_bank_bit_i,
	input wire logic indirect_i,
	input wire logic [mmdec_pkg::DIRECT_W-1:0] direct_field_i,
	input wire logic [mmdec_pkg::DADDR_W-1:0] file_select_pointer_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [mmdec_pkg::DATA_W-1:0] wdata_i,
	input wire logic [mmdec_pkg::DATA_W-1:0] sfr_rdata_i,
	output logic sfr_sel_o,
	output logic sfr_we_o,
	output logic [mmdec_pkg::DADDR_W-1:0] data_addr_o,
	output logic [mmdec_pkg::DATA_W-1:0] rdata_o,
	output logic rvalid_o,
	output logic reserved_bits_set_o
);
	import mmdec_pkg::*;

	localparam int PHYS_W = (VARIANT == MMDEC_LARGE) ? PADDR_LARGE_W : PADDR_SMALL_W;

	logic [PC_W-1:0] pc_reg;
	logic [PC_W-1:0] pc_next;
	logic [PWORD_W-1:0] instr_reg;
	logic [DADDR_W-1:0] addr;
	logic [6:0] offs;
	logic bank;
	logic is_sfr;
	logic is_ram;
	// One index bit above the package width gives bank 1 its own slots.
	logic [RAM_IDX_W:0] ram_idx;
	logic [DATA_W-1:0] ram_rdata;
	logic [DATA_W-1:0] rdata_reg;
	logic rvalid_reg;

	// ==========================================================
	// Program counter
	// An interrupt wins over a jump, which wins over a plain increment.
	always_comb begin
		pc_next = pc_reg;
		if (irq_take_i) begin
			pc_next = INT_VECTOR;
		end else if (pc_load_i) begin
			pc_next = pc_load_val_i;
		end else if (pc_inc_i) begin
			pc_next = PC_W'(pc_reg + 13'h0001);
		end
	end

	// The counter always holds the full logical address; only the fetch is folded.
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			pc_reg <= RESET_VECTOR;
		end else begin
			pc_reg <= pc_next;
		end
	end

	assign pc_o = pc_reg;

	// ==========================================================
	// Fetch address wrap
	// drop upper bits
	// Zeroing the upper bits is cheaper than a modulo and matches silicon wrap.
	assign fetch_addr_o = {{(PC_W - PHYS_W){1'b0}}, pc_reg[PHYS_W-1:0]};

	// Fetched word is captured so the instruction output comes from a flop.
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			instr_reg <= '0;
		end else begin
			instr_reg <= prog_word_i;
		end
	end

	assign instr_o = instr_reg;

	// ==========================================================
	// Data address formation
	always_comb begin
		if (indirect_i) begin
			addr = file_select_pointer_i;
		end else begin
			addr = {bank_select_bit_i, direct_field_i};
		end
	end

	assign bank = addr[7];
	assign offs = addr[6:0];
	assign data_addr_o = addr;

	// ==========================================================
	// Region decode
	always_comb begin
		is_sfr = 1'b0;
		is_ram = 1'b0;
		ram_idx = '0;
		if (offs < SFR_COUNT) begin
			is_sfr = 1'b1;
		end else if (!bank) begin
			if (VARIANT == MMDEC_LARGE) begin
				is_ram = (offs >= LARGE_RAM_LO) && (offs <= BANK0_RAM_HI);
			end else begin
				is_ram = (offs >= SMALL_RAM_LO) && (offs <= BANK0_RAM_HI);
			end
			ram_idx = {1'b0, offs};
		end else if (addr >= ALIAS_LO) begin
			is_ram = 1'b1;
			ram_idx = {1'b0, offs};
		end else if ((VARIANT == MMDEC_LARGE) && (addr >= BANK1_RAM_LO) && (addr <= BANK1_RAM_HI)) begin
			// bank 1 large range
			// Bank 1 RAM sits in slots 80h to CFh, above every bank 0 slot.
			is_ram = 1'b1;
			ram_idx = {1'b0, addr[6:0]} + 8'h60;
		end
	end

	// The mapping above places A0h at slot 80h, so bank 1 RAM never shares a slot with bank 0;
	// only F0h to FFh reuse slots 70h to 7Fh, and the small variant leaves the upper slots idle.

	assign sfr_sel_o = is_sfr;
	assign sfr_we_o = is_sfr && wr_i;

	// ==========================================================
	// RAM storage
	mmdec_ram #(
		.DEPTH(2 * RAM_DEPTH),
		.IDX_W(RAM_IDX_W + 1),
		.WIDTH(DATA_W)
	) u_ram (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.we_i(is_ram && wr_i),
		.widx_i(ram_idx),
		.wdata_i(wdata_i),
		.ridx_i(ram_idx),
		.rdata_o(ram_rdata)
	);

	// ==========================================================
	// Read data return, one cycle after the request.
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rdata_reg <= DATA_RESET;
		end else if (rd_i) begin
			if (is_sfr) begin
				rdata_reg <= sfr_rdata_i;
			end else if (is_ram) begin
				rdata_reg <= ram_rdata;
			end else begin
				rdata_reg <= DATA_RESET;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= rd_i;
		end
	end

	assign rdata_o = rdata_reg;
	assign rvalid_o = rvalid_reg;

	// ==========================================================
	// Reserved status bits are ignored by the decode; this flag only reports misuse.
	// reserved bits watched
	assign reserved_bits_set_o = upper_bank_bit_i | indirect_bank_bit_i;
endmodule
`default_nettype wire

// *** bench/mmdec_top_sva.sv ***
/* Port checker for mmdec_top.
   Assumes one clock domain and the synchronous low reset. */
`timescale 1ns/1ps
`default_nettype none
module mmdec_top_sva
	import mmdec_pkg::*;
	#(parameter mmdec_variant_t VARIANT = MMDEC_SMALL) (
	input wire logic clk_i, nrst_i, pc_load_i, pc_inc_i, irq_take_i,
	input wire logic indirect_i, bank_select_bit_i, rd_i, sfr_sel_o, rvalid_o,
	input wire logic [12:0] pc_o, fetch_addr_o,
	input wire logic [6:0] direct_field_i,
	input wire logic [7:0] file_select_pointer_i, sfr_rdata_i, data_addr_o, rdata_o
);
	// ==========================================================
	// Checks
	// Everything runs on the core clock, so one default serves all.
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	logic [12:0] mask;
	// Only the implemented words may show in the fetch address.
	assign mask = (VARIANT == MMDEC_LARGE) ? 13'h07ff : 13'h03ff;
	a_reset_start: assert property ($rose(nrst_i) |-> pc_o == RESET_VECTOR)
		else $error("pc not at reset vector");
	a_irq_vector: assert property (irq_take_i |=> pc_o == INT_VECTOR)
		else $error("interrupt vector not loaded");
	a_pc_step: assert property (pc_inc_i && !pc_load_i && !irq_take_i |=> pc_o == $past(pc_o) + 13'h1)
		else $error("pc did not step by one");
	a_fetch_wrap: assert property (fetch_addr_o == (pc_o & mask))
		else $error("fetch address not wrapped");
	a_direct_addr: assert property (!indirect_i |-> data_addr_o == {bank_select_bit_i, direct_field_i})
		else $error("direct address badly formed");
	a_pointer_addr: assert property (indirect_i |-> data_addr_o == file_select_pointer_i)
		else $error("pointer address not used");
	a_sfr_read: assert property (rd_i && sfr_sel_o |=> rvalid_o && rdata_o == $past(sfr_rdata_i))
		else $error("register read data lost");
	a_sfr_region: assert property (sfr_sel_o == (data_addr_o[6:0] < 7'h20))
		else $error("register region wrong");
	c_irq: cover property (irq_take_i);
	c_ptr_read: cover property (rd_i && indirect_i);
	c_sfr_read: cover property (rd_i && sfr_sel_o);
endmodule
bind mmdec_top mmdec_top_sva #(.VARIANT(VARIANT)) u_sva (.*);
`default_nettype wire

// *** bench/mmdec_far_model.sv ***
/* Far side model: program memory and special registers.
   Assumes its addresses come straight from mmdec_top. */
`timescale 1ns/1ps
`default_nettype none
module mmdec_far_model (
	input wire logic [12:0] fetch_addr_i,
	input wire logic [7:0] data_addr_i,
	output logic [13:0] prog_word_o,
	output logic [7:0] sfr_rdata_o
);
	// ==========================================================
	// Memories
	// A marker nibble over the low ten fetch address bits; upper bits never reach the word.
	// only 1K words
	assign prog_word_o = {4'h5, fetch_addr_i[9:0]};
	// Inverted address, never equal to the RAM patterns of the bench.
	// registers answer combinationally
	assign sfr_rdata_o = ~data_addr_i;
endmodule
`default_nettype wire

// *** bench/tb_memory_map_decoder.sv ***
/* Self-checking bench for mmdec_top, small and large variants.
   Assumes the far side model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_memory_map_decoder;
	import mmdec_pkg::*;
	logic clk_i = 0, nrst_i = 0, pc_load_i = 0, pc_inc_i = 0, irq_take_i = 0, indirect_i = 0;
	logic bank_select_bit_i = 0, rd_i = 0, wr_i = 0;
	logic upper_bank_bit_i = 0, indirect_bank_bit_i = 0;
	logic [12:0] pc_load_val_i = 0, pc_o, fetch_addr_o;
	logic [13:0] prog_word_i, instr_o;
	logic [6:0] direct_field_i = 0;
	logic [7:0] file_select_pointer_i = 0, wdata_i = 0, sfr_rdata_i, data_addr_o, rdata_o;
	logic sfr_sel_o, sfr_we_o, rvalid_o, reserved_bits_set_o;
	logic [12:0] fetch_l;
	logic [7:0] rdata_l;
	int mismatches = 0, compares = 0;
	mmdec_top #(.VARIANT(MMDEC_SMALL)) dut_u (.*);
	// Large variant shares every input; only its fetch and read data are judged.
	mmdec_top #(.VARIANT(MMDEC_LARGE)) dut_l (.clk_i(clk_i), .nrst_i(nrst_i), .pc_load_i(pc_load_i),
		.pc_load_val_i(pc_load_val_i), .pc_inc_i(pc_inc_i), .irq_take_i(irq_take_i), .pc_o(),
		.fetch_addr_o(fetch_l), .prog_word_i(prog_word_i), .instr_o(), .bank_select_bit_i(bank_select_bit_i),
		.upper_bank_bit_i(upper_bank_bit_i), .indirect_bank_bit_i(indirect_bank_bit_i), .indirect_i(indirect_i),
		.direct_field_i(direct_field_i), .file_select_pointer_i(file_select_pointer_i), .rd_i(rd_i), .wr_i(wr_i),
		.wdata_i(wdata_i), .sfr_rdata_i(sfr_rdata_i), .sfr_sel_o(), .sfr_we_o(), .data_addr_o(),
		.rdata_o(rdata_l), .rvalid_o(), .reserved_bits_set_o());
	mmdec_far_model far_u (.fetch_addr_i(fetch_addr_o), .data_addr_i(data_addr_o),
		.prog_word_o(prog_word_i), .sfr_rdata_o(sfr_rdata_i));
	// ==========================================================
	// Helpers
	// Clock of 25 ns period.
	always #12.5 clk_i = ~clk_i;
	task stp;
		@(posedge clk_i);
		#2;
	endtask
	task chk(input logic [15:0] s, input logic [15:0] e, input string n);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	// One data cycle; a read is judged on the registered answer.
	// A quiet cycle follows each access so strobes never toggle twice in one step.
	task acc(input logic ind, input logic [7:0] a, input logic w, input logic [7:0] d, input logic [7:0] e,
		input logic [7:0] el);
		indirect_i = ind;
		bank_select_bit_i = a[7];
		direct_field_i = a[6:0];
		file_select_pointer_i = a;
		rd_i = !w;
		wr_i = w;
		wdata_i = d;
		stp;
		rd_i = 0;
		wr_i = 0;
		chk(rvalid_o, !w, "rvalid");
		if (!w) begin
			chk(rdata_o, e, "rdata");
			chk(rdata_l, el, "rdata_large");
		end
		stp;
	endtask
	task end_sim;
		if (mismatches == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task t_pc;
		pc_load_val_i = 13'h1ffe;
		pc_load_i = 1;
		stp;
		pc_load_i = 0;
		pc_inc_i = 1;
		stp;
		stp;
		chk(pc_o, 0, "pc_wrap");
		pc_inc_i = 0;
		pc_load_val_i = 13'h1c05;
		pc_load_i = 1;
		irq_take_i = 1;
		stp;
		chk(pc_o, 4, "pc_irq");
		irq_take_i = 0;
		stp;
		pc_load_i = 0;
		chk(fetch_addr_o, 5, "fetch");
		chk(fetch_l, 13'h0405, "fetch_large");
		stp;
		chk(instr_o, 16'h1405, "instr");
	endtask
	task t_ram;
		acc(0, 8'h7f, 1, 8'h5a, 0, 0);
		acc(0, 8'hff, 0, 0, 8'h5a, 8'h5a);
		acc(1, 8'h7f, 0, 0, 8'h5a, 8'h5a);
		acc(1, 8'hf0, 1, 8'h3c, 0, 0);
		acc(0, 8'h70, 0, 0, 8'h3c, 8'h3c);
		acc(0, 8'h40, 1, 8'ha5, 0, 0);
		acc(0, 8'hc0, 0, 0, 0, 0);
		acc(0, 8'h40, 0, 0, 8'ha5, 8'ha5);
		acc(0, 8'h20, 1, 8'hff, 0, 0);
		acc(0, 8'h20, 0, 0, 0, 8'hff);
		acc(0, 8'h85, 0, 0, 8'h7a, 8'h7a);
		acc(0, 8'hc0, 1, 8'h11, 0, 0);
		acc(0, 8'h20, 0, 0, 0, 8'hff);
		acc(0, 8'hc0, 0, 0, 0, 8'h11);
	endtask
	// Watchdog at 800 cycles, far beyond the 40 or so cycles the run needs.
	initial begin
		#20000;
		mismatches++;
		end_sim;
	end
	// Reset for five cycles, then the scenarios.
	initial begin
		repeat (5) @(posedge clk_i);
		#2;
		nrst_i = 1;
		chk(pc_o, 0, "pc_reset");
		t_pc;
		t_ram;
		end_sim;
	end
endmodule
`default_nettype wire
